// File: logic_block_pkg.sv
// How it works
// R01: eight logic cells, one lookup and flop each
// R02: sixteen-entry one-bit table addressed by four inputs
// R03: d flop with optional enable and set/reset
// R04: global clear of all flops after configuration
// R05: fast carry in from previous, out to next
// R06: one clock enable shared by all cells
// R07: one local set/reset, async or sync
// R08: clock from eight global lines or fabric
// R09: output shows lookup result or stored value
// R10: unused set/reset never touches the flops
// R11: enable low holds flops across clock edges
// R12: carry out is majority of carry and inputs
package logic_block_pkg;

    // structure of the block
    localparam int CELLS      = 8;    // logic cells in one group
    localparam int LUT_INPUTS = 4;    // data inputs per lookup
    localparam int LUT_SIZE   = 16;   // entries of one lookup table
    localparam int GBUF_LINES = 8;    // global clock lines to choose from

    // register port
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register byte offsets
    localparam logic [7:0] LUT_BASE_OFS = 8'h00; // eight tables, one word each
    localparam logic [7:0] CTRL_OFS     = 8'h20; // shared cell configuration
    localparam logic [7:0] DONE_OFS     = 8'h24; // configuration complete
    localparam logic [7:0] STATUS_OFS   = 8'h28; // flop and output state

    // field positions of the status word
    localparam int ST_Q_LSB   = 0;
    localparam int ST_OUT_LSB = 8;
    localparam int ST_CONF    = 16;

    // clock source code that picks the fabric line
    localparam logic [3:0] CLK_SEL_FABRIC = 4'h8;

    // values after reset
    localparam logic [15:0] LUT_RST  = 16'h0000;
    localparam logic [15:0] CTRL_RST = 16'h0000;

    // shared configuration carried as one word
    typedef struct packed {
        logic [3:0] clk_sel;   // 0..7 global line, 8 fabric
        logic       sr_to_set; // set/reset drives ones when high
        logic       sr_async;  // set/reset acts without the block clock
        logic       sr_used;   // set/reset input connected
        logic       ce_used;   // clock enable input connected
        logic [7:0] out_sel;   // per cell: 1 stored value, 0 lookup
    } cfg_t;

    // controls handed to every cell at once
    typedef struct packed {
        logic tick;    // active edge of the selected block clock
        logic ce;      // effective clock enable
        logic sr_now;  // set/reset acting this cycle
        logic sr_val;  // value forced by set/reset
        logic clear;   // global clear after configuration
    } cell_ctl_t;

    // configuration progress, gray coded
    typedef enum logic [1:0] {
        ST_UNCONF = 2'b00,
        ST_CLEAR  = 2'b01,
        ST_RUN    = 2'b11
    } conf_state_t;

endpackage : logic_block_pkg

// File: logic_cell.sv
`timescale 1ns/1ps
// one logic cell: lookup, carry and storage
module logic_cell (
    input  wire logic                          MCLK,
    input  wire logic                          RST_B,
    input  wire logic [15:0]                   lut_init,  // table contents
    input  wire logic [3:0]                    data_in,   // lookup address
    input  wire logic                          carry_chain_in,
    input  wire logic_block_pkg::cell_ctl_t    ctl,
    output logic                               lut_out,
    output logic                               carry_chain_out,
    output logic                               q
);
    logic q_reg;   // cell_flip_flop
    logic q_next;

    // table read: any function of four inputs
    assign lut_out = lut_init[data_in];                              // R02

    // majority of carry and inputs 1 and 2 gives a ripple adder
    assign carry_chain_out = (carry_chain_in & data_in[1])
                           | (carry_chain_in & data_in[2])
                           | (data_in[1] & data_in[2]);             // R05 R12

    // clear first, then set/reset, then enabled load, else hold
    always_comb begin
        q_next = q_reg;
        if (ctl.clear) begin
            q_next = 1'b0;                                           // R04
        end else if (ctl.sr_now) begin
            q_next = ctl.sr_val;                                     // R07
        end else if (ctl.tick && ctl.ce) begin
            q_next = lut_out;                                        // R03
        end
    end

    // storage element
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            q_reg <= 1'b0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign q = q_reg;

endmodule : logic_cell

// File: logic_block_group.sv
`timescale 1ns/1ps
// eight cells sharing clock source, enable and set/reset
module logic_block_group (
    input  wire logic                   MCLK,
    input  wire logic                   RST_B,
    input  wire logic [7:0]             ADDR,
    input  wire logic [31:0]            WR_DATA,
    input  wire logic                   WR_EN,
    input  wire logic                   RD_EN,
    output logic      [31:0]            RD_DATA,
    input  wire logic [31:0]            CELL_IN,     // four bits per cell
    input  wire logic                   CLK_ENABLE,
    input  wire logic                   LOCAL_SR,
    input  wire logic [7:0]             GBUF_CLK,
    input  wire logic                   FABRIC_CLK,
    input  wire logic                   CARRY_IN,
    output logic      [7:0]             CELL_OUT,
    output logic                        CARRY_OUT,
    output logic                        CONFIG_DONE
);
    // configuration storage
    logic [15:0]                  lut_reg [8];   // one table per cell
    logic_block_pkg::cfg_t        ctrl_reg;      // shared configuration
    logic_block_pkg::conf_state_t state_reg;     // configuration progress
    logic_block_pkg::conf_state_t state_next;
    logic [31:0]                  rd_reg;        // read data register
    logic [31:0]                  rd_next;
    logic                         clk_prev_reg;  // last selected clock level
    logic [7:0]                   out_reg;       // cell outputs
    logic [7:0]                   out_next;
    logic                         carry_reg;     // block carry out
    logic                         done_reg;      // configuration flag out

    // cell-level wires
    logic [7:0]                   lut_w;         // lookup results
    logic [7:0]                   q_w;           // flop contents
    logic [8:0]                   chain_w;       // carry ripple
    logic_block_pkg::cell_ctl_t   ctl_w;

    // register decode
    wire       lut_hit  = (ADDR[7:5] == logic_block_pkg::LUT_BASE_OFS[7:5])
                       && (ADDR[1:0] == 2'h0);
    wire [2:0] lut_idx  = ADDR[4:2];
    wire       ctrl_hit = (ADDR == logic_block_pkg::CTRL_OFS);
    wire       done_hit = (ADDR == logic_block_pkg::DONE_OFS);
    wire       stat_hit = (ADDR == logic_block_pkg::STATUS_OFS);
    wire       lut_wr   = WR_EN && lut_hit;
    wire       ctrl_wr  = WR_EN && ctrl_hit;
    // writing one to the done word ends configuration
    wire       done_wr  = WR_EN && done_hit && WR_DATA[0];

    // clock source selection: global line or fabric
    wire       fab_sel  =
        (ctrl_reg.clk_sel == logic_block_pkg::CLK_SEL_FABRIC);
    wire       clk_sel_w = fab_sel ? FABRIC_CLK
                                   : GBUF_CLK[ctrl_reg.clk_sel[2:0]];  // R08
    // codes 9..15 pick no source, so the block clock stays still
    wire       sel_ok   = !ctrl_reg.clk_sel[3] || fab_sel;
    wire       run_w    = (state_reg == logic_block_pkg::ST_RUN);
    // rising edge of the selected source, common to all cells
    wire       tick_w   = run_w && sel_ok && clk_sel_w && !clk_prev_reg; // R08

    // shared enable: an unused enable reads as always on
    wire       ce_w     = !ctrl_reg.ce_used || CLK_ENABLE;        // R06 R11
    // an unused set/reset never acts
    wire       sr_act   = ctrl_reg.sr_used && LOCAL_SR && run_w;    // R10
    // async acts at once, sync only at the block clock edge
    wire       sr_now_w = sr_act && (ctrl_reg.sr_async || tick_w);  // R07

    assign ctl_w.tick   = tick_w;
    assign ctl_w.ce     = ce_w;
    assign ctl_w.sr_now = sr_now_w;
    assign ctl_w.sr_val = ctrl_reg.sr_to_set;
    assign ctl_w.clear  = (state_reg == logic_block_pkg::ST_CLEAR);  // R04

    // the block carry enters cell zero
    assign chain_w[0] = CARRY_IN;

    // eight identical cells on one carry chain
    for (genvar i = 0; i < logic_block_pkg::CELLS; i++) begin : g_cell // R01
        logic_cell u_cell (
            .MCLK            (MCLK),
            .RST_B           (RST_B),
            .lut_init        (lut_reg[i]),
            .data_in         (CELL_IN[4*i +: 4]),
            .carry_chain_in  (chain_w[i]),
            .ctl             (ctl_w),
            .lut_out         (lut_w[i]),
            .carry_chain_out (chain_w[i+1]),                         // R05
            .q               (q_w[i])
        );
    end

    // output choice per cell: stored value or lookup result
    assign out_next = (ctrl_reg.out_sel & q_w)
                    | (~ctrl_reg.out_sel & lut_w);                   // R09

    // configuration sequence: clear once right after completion
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            logic_block_pkg::ST_UNCONF: begin
                // tables load freely, flops held at zero
                if (done_wr) begin
                    state_next = logic_block_pkg::ST_CLEAR;          // R04
                end
            end
            logic_block_pkg::ST_CLEAR: begin
                // one cycle of global clear, then run
                state_next = logic_block_pkg::ST_RUN;
            end
            logic_block_pkg::ST_RUN: begin
                // stays configured until the next reset
                state_next = logic_block_pkg::ST_RUN;
            end
            default: begin
                state_next = logic_block_pkg::ST_UNCONF;
            end
        endcase
    end

    // read mux, unmapped offsets answer zero
    always_comb begin
        rd_next = '0;
        // only a read strobe loads data, so the bus idles at zero
        if (RD_EN) begin
            if (lut_hit) begin
                rd_next[15:0] = lut_reg[lut_idx];
            end else if (ctrl_hit) begin
                rd_next[15:0] = ctrl_reg;
            end else if (done_hit) begin
                rd_next[0] = run_w;
            end else if (stat_hit) begin
                // flops, outputs and the done bit in one word
                rd_next[logic_block_pkg::ST_Q_LSB +: 8]   = q_w;
                rd_next[logic_block_pkg::ST_OUT_LSB +: 8] = out_reg;
                rd_next[logic_block_pkg::ST_CONF]         = run_w;
            end
        end
    end

    // lookup tables, written at any time
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            for (int k = 0; k < 8; k++) begin
                lut_reg[k] <= logic_block_pkg::LUT_RST;
            end
        end else if (lut_wr) begin
            lut_reg[lut_idx] <= WR_DATA[15:0];
        end
    end

    // shared configuration word
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            ctrl_reg <= logic_block_pkg::CTRL_RST;
        end else if (ctrl_wr) begin
            ctrl_reg <= WR_DATA[15:0];
        end
    end

    // sequence state and edge detect history
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            state_reg    <= logic_block_pkg::ST_UNCONF;
            clk_prev_reg <= 1'b0;
        end else begin
            state_reg    <= state_next;
            clk_prev_reg <= clk_sel_w;
        end
    end

    // registered outputs; costs one cycle of latency on every path
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            rd_reg    <= '0;
            out_reg   <= '0;
            carry_reg <= 1'b0;
            done_reg  <= 1'b0;
        end else begin
            rd_reg    <= rd_next;
            out_reg   <= out_next;
            carry_reg <= chain_w[8];                                 // R05
            done_reg  <= run_w;
        end
    end

    // every port comes straight from a flop above
    assign RD_DATA     = rd_reg;
    assign CELL_OUT    = out_reg;
    assign CARRY_OUT   = carry_reg;
    assign CONFIG_DONE = done_reg;

    // checks, all on the single clock
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_B);

    // expected ripple result, recomputed independently
    logic [8:0] maj_w;
    assign maj_w[0] = CARRY_IN;
    for (genvar j = 0; j < 8; j++) begin : g_maj
        assign maj_w[j+1] = (maj_w[j] + CELL_IN[4*j+1]
                           + CELL_IN[4*j+2]) >= 2'h2;
    end

    // expected lookup per cell, read straight from the tables
    logic [7:0] exp_lut_w;
    for (genvar j = 0; j < 8; j++) begin : g_exp
        assign exp_lut_w[j] = lut_reg[j][CELL_IN[4*j +: 4]];
    end

    // flops idle outside run and clear
    a_idle_flops: assert property (                                  // R01
        state_reg == logic_block_pkg::ST_UNCONF |=> $stable(q_w))
        else $error("flops moved before configuration");

    // cell zero on the lookup path follows its table
    a_lut_lookup: assert property (                                  // R02
        !ctrl_reg.out_sel[0] && !ctrl_wr && !lut_wr
        |=> CELL_OUT[0] == $past(lut_reg[0][CELL_IN[3:0]]))
        else $error("lookup output wrong");

    // while running with set/reset idle, enable low freezes every flop
    a_enable_hold: assert property (                                 // R11
        run_w && ctrl_reg.ce_used && !CLK_ENABLE && !sr_act
        |=> q_w == $past(q_w))
        else $error("flops changed with enable low");

    // done write, one clear cycle, then the done flag
    a_config_clear: assert property (                                // R04
        state_reg == logic_block_pkg::ST_UNCONF && done_wr
        ##1 1'b1 |=> q_w == 8'h00 ##1 CONFIG_DONE)
        else $error("flops not cleared after configuration");

    // registered carry matches the independent ripple
    a_carry_major: assert property (                                 // R12
        1'b1 |=> CARRY_OUT == $past(maj_w[8]))
        else $error("carry chain result wrong");

    // async mode forces the flops at the next system edge
    a_sr_async: assert property (                                    // R07
        ctrl_reg.sr_used && ctrl_reg.sr_async && LOCAL_SR && run_w
        |=> q_w == {8{$past(ctrl_reg.sr_to_set)}})
        else $error("async set/reset did not act");

    // while running, without a block edge nothing but set/reset moves flops
    a_no_edge_hold: assert property (                                // R08
        run_w && !tick_w && !sr_act |=> $stable(q_w))
        else $error("flops moved without block clock edge");

    // all cells on the stored path show their flops
    a_out_stored: assert property (                                  // R09
        ctrl_reg.out_sel == 8'hff && !ctrl_wr
        |=> CELL_OUT == $past(q_w))
        else $error("stored value not on output");

    a_sr_unused: assert property (                                   // R10
        run_w && !ctrl_reg.sr_used && tick_w && !ctrl_reg.ce_used
        |=> q_w == $past(lut_w))
        else $error("flops not loaded from lookup");

    a_read_zero: assert property (
        RD_EN && !lut_hit && !ctrl_hit && !done_hit && !stat_hit
        |=> RD_DATA == 32'h0000_0000)
        else $error("unmapped read not zero");

    // all cells on the lookup path show their own table
    a_lut_all: assert property (                                     // R02
        ctrl_reg.out_sel == 8'h00
        |=> CELL_OUT == $past(exp_lut_w))
        else $error("lookup output of a cell wrong");

    // per-cell choice between stored value and lookup
    a_out_mixed: assert property (                                   // R09
        1'b1 |=> CELL_OUT == $past((ctrl_reg.out_sel & q_w)
                                 | (~ctrl_reg.out_sel & exp_lut_w)))
        else $error("cell output choice wrong");

    // an enabled block edge loads every cell from its table
    a_enable_load: assert property (                                 // R06
        run_w && tick_w && ce_w && !sr_act
        |=> q_w == $past(exp_lut_w))
        else $error("flops not loaded on enabled edge");

    // sync set/reset lands at the block clock edge
    a_sr_sync: assert property (                                     // R07
        sr_act && !ctrl_reg.sr_async && tick_w
        |=> q_w == {8{$past(ctrl_reg.sr_to_set)}})
        else $error("sync set/reset did not act");

    // configuration is one-way: the done flag never drops
    a_done_sticky: assert property (                                 // R04
        CONFIG_DONE |=> CONFIG_DONE)
        else $error("configuration flag dropped");

    c_config_done: cover property (
        state_reg == logic_block_pkg::ST_CLEAR ##1 run_w);
    c_sync_sr: cover property (
        sr_act && !ctrl_reg.sr_async && tick_w);
    c_carry_ripple: cover property (CARRY_IN && maj_w[8] && tick_w);
    c_fabric_clock: cover property (fab_sel && tick_w && ce_w);
    c_async_sr: cover property (sr_act && ctrl_reg.sr_async);

endmodule : logic_block_group

// File: clock_fabric.sv
`timescale 1ns/1ps
// global clock lines and fabric clock line as seen by one logic group
module clock_fabric (
    input  wire logic       MCLK,
    input  wire logic       RST_B,
    input  wire logic [8:0] line_on,    // [7:0] global lines, [8] fabric
    output logic      [7:0] GBUF_CLK,   // global clock lines
    output logic            FABRIC_CLK  // fabric clock line
);
    logic [1:0] phase_reg; // divides mclk by four for every line

    // enabled lines run two cycles high, two low; idle lines stand low
    // so that switching a line off never fakes a rising edge
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            phase_reg  <= 2'h0;
            GBUF_CLK   <= 8'h00;
            FABRIC_CLK <= 1'b0;
        end else begin
            phase_reg  <= phase_reg + 2'h1;
            GBUF_CLK   <= line_on[7:0] & {8{phase_reg[1]}};
            FABRIC_CLK <= line_on[8] & phase_reg[1];
        end
    end
endmodule : clock_fabric

// File: tb.sv
`timescale 1ns/1ps
// self-checking bench for one logic group
module tb;
    logic        MCLK, RST_B, WR_EN, RD_EN, CLK_ENABLE, LOCAL_SR;
    logic        CARRY_IN, FABRIC_CLK, CARRY_OUT, CONFIG_DONE;
    logic [7:0]  ADDR, CELL_OUT, GBUF_CLK;
    logic [31:0] WR_DATA, RD_DATA, CELL_IN;
    logic [8:0]  line_on;   // lines the fabric model toggles
    int          err_count, n_tests, cycles;
    localparam int LIMIT = 20000; // the run needs about five hundred

    logic_block_group dut (.MCLK(MCLK), .RST_B(RST_B), .ADDR(ADDR),
        .WR_DATA(WR_DATA), .WR_EN(WR_EN), .RD_EN(RD_EN), .RD_DATA(RD_DATA),
        .CELL_IN(CELL_IN), .CLK_ENABLE(CLK_ENABLE), .LOCAL_SR(LOCAL_SR),
        .GBUF_CLK(GBUF_CLK), .FABRIC_CLK(FABRIC_CLK), .CARRY_IN(CARRY_IN),
        .CELL_OUT(CELL_OUT), .CARRY_OUT(CARRY_OUT),
        .CONFIG_DONE(CONFIG_DONE));
    clock_fabric fab (.MCLK(MCLK), .RST_B(RST_B), .line_on(line_on),
        .GBUF_CLK(GBUF_CLK), .FABRIC_CLK(FABRIC_CLK));

    // 20 MHz system clock
    initial begin
        MCLK = 1'b0;
        forever #25 MCLK = ~MCLK;
    end

    // hang guard: a run that overstays counts as a mismatch
    always @(posedge MCLK) begin
        cycles++;
        if (cycles == LIMIT) begin
            err_count++;
            summarize();
        end
    end

    // table of cell i: distinct per cell so a swapped cell shows
    function automatic logic [15:0] lut_of(input int i);
        return 16'h6996 ^ (16'h0101 << i);
    endfunction : lut_of

    // expected outputs of all cells fed the same lookup address
    function automatic logic [7:0] exp_out(input logic [3:0] a);
        logic [7:0]  e;
        logic [15:0] t;
        for (int i = 0; i < 8; i++) begin
            t = lut_of(i);
            e[i] = t[a];
        end
        return e;
    endfunction : exp_out

    // control word: clock source, set/reset mode, enable use, out select
    function automatic logic [31:0] ctl(input logic [3:0] sel,
        input logic ts, as, su, cu, input logic [7:0] os);
        return {16'h0000, sel, ts, as, su, cu, os};
    endfunction : ctl

    task automatic summarize();
        $display("mismatches %0d, comparisons %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    task automatic chk(input string what, input logic [31:0] exp, got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge MCLK);
        #1;
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge MCLK);
        WR_EN <= 1'b1;
        ADDR <= a;
        WR_DATA <= d;
        @(posedge MCLK);
        WR_EN <= 1'b0;
    endtask : wr

    // read data stands only in the cycle after the strobe
    task automatic rd(input string what, input logic [7:0] a,
        input logic [31:0] exp);
        @(posedge MCLK);
        RD_EN <= 1'b1;
        ADDR <= a;
        @(posedge MCLK);
        RD_EN <= 1'b0;
        #1;
        chk(what, exp, RD_DATA);
    endtask : rd

    // let one line run for a few block clock periods, then stop it
    task automatic pulse(input int line);
        line_on <= 9'h001 << line;
        cyc(10);
        line_on <= 9'h000;
        cyc(4);
    endtask : pulse

    task automatic t_reset();
        rd("ctrl", 8'h20, 32'h0);
        rd("table1", 8'h04, 32'h0);
        rd("unmapped", 8'h40, 32'h0);
        wr(8'h24, 32'h0);                           // bit0 low is ignored
        rd("done", 8'h24, 32'h0);
        chk("config_done", 32'h0, {31'h0, CONFIG_DONE});
    endtask : t_reset

    task automatic t_config();
        for (int i = 0; i < 8; i++) wr(8'h4 * i, {16'h0, lut_of(i)});
        rd("table7", 8'h1c, {16'h0, lut_of(7)});
        wr(8'h20, ctl(4'h0, 0, 0, 0, 1, 8'hff));
        CLK_ENABLE <= 1'b1;
        CELL_IN <= {8{4'h3}};
        pulse(0);
        rd("status unconf", 8'h28, 32'h0);
        wr(8'h24, 32'h1);
        cyc(3);
        chk("config_done", 32'h1, {31'h0, CONFIG_DONE});
        rd("status cleared", 8'h28, 32'h10000);
    endtask : t_config

    task automatic t_lookup();
        wr(8'h20, ctl(4'h0, 0, 0, 0, 1, 8'h00));
        for (int a = 0; a < 16; a++) begin
            CELL_IN <= {8{a[3:0]}};
            cyc(3);
            chk("lookup", {24'h0, exp_out(a[3:0])}, {24'h0, CELL_OUT});
        end
        // flops still cleared: high half shows zero, low half the table
        CELL_IN <= {8{4'h1}};
        wr(8'h20, ctl(4'h0, 0, 0, 0, 1, 8'hf0));
        cyc(2);
        chk("mixed", {24'h0, exp_out(4'h1) & 8'h0f}, {24'h0, CELL_OUT});
    endtask : t_lookup

    task automatic t_carry();
        logic c;
        logic [31:0] v;
        for (int j = 0; j < 8; j++) begin
            v = 32'h6666_0000 ^ (32'h1234_5679 * j);
            CELL_IN <= v;
            CARRY_IN <= j[0];
            c = j[0];
            for (int i = 0; i < 8; i++)
                c = (c & v[4*i+1]) | (c & v[4*i+2]) | (v[4*i+1] & v[4*i+2]);
            cyc(3);
            chk("carry", {31'h0, c}, {31'h0, CARRY_OUT});
        end
    endtask : t_carry

    // each source loads the flops; another running line must not
    task automatic t_clock();
        logic [7:0] e;
        for (int k = 0; k < 9; k++) begin
            wr(8'h20, ctl(k[3:0], 0, 0, 0, 1, 8'hff));
            CELL_IN <= {8{k[3:0] + 4'h3}};
            e = exp_out(k[3:0] + 4'h3);
            pulse(k);
            rd("flops load", 8'h28, {15'h0, 1'b1, e, e});
            CELL_IN <= {8{k[3:0] + 4'h9}};
            pulse((k + 1) % 9);
            rd("flops other", 8'h28, {15'h0, 1'b1, e, e});
        end
    endtask : t_clock

    task automatic t_enable();
        logic [7:0] e;
        e = exp_out(4'hb);                  // left by the fabric line pass
        wr(8'h20, ctl(4'h0, 0, 0, 0, 1, 8'hff));
        CLK_ENABLE <= 1'b0;
        CELL_IN <= {8{4'h5}};
        pulse(0);
        rd("flops hold", 8'h28, {15'h0, 1'b1, e, e});
        wr(8'h20, ctl(4'h0, 0, 0, 0, 0, 8'hff));
        pulse(0);
        e = exp_out(4'h5);
        rd("flops no ce", 8'h28, {15'h0, 1'b1, e, e});
    endtask : t_enable

    task automatic t_setreset();
        logic [7:0] e;
        e = exp_out(4'h5);
        wr(8'h20, ctl(4'h0, 1, 1, 0, 1, 8'hff));
        LOCAL_SR <= 1'b1;
        cyc(4);
        rd("sr unused", 8'h28, {15'h0, 1'b1, e, e});
        wr(8'h20, ctl(4'h0, 1, 1, 1, 1, 8'hff));
        cyc(3);
        rd("async set", 8'h28, 32'h1ffff);
        wr(8'h20, ctl(4'h0, 0, 0, 1, 1, 8'hff));
        cyc(4);
        rd("sync waits", 8'h28, 32'h1ffff);
        pulse(0);
        rd("sync reset", 8'h28, 32'h10000);
        LOCAL_SR <= 1'b0;
    endtask : t_setreset

    // main sequence: all inputs set at time zero, reset for six cycles
    initial begin
        RST_B = 1'b0;
        WR_EN = 1'b0;
        RD_EN = 1'b0;
        ADDR = 8'h00;
        WR_DATA = 32'h0;
        CELL_IN = 32'h0;
        CLK_ENABLE = 1'b0;
        LOCAL_SR = 1'b0;
        CARRY_IN = 1'b0;
        line_on = 9'h000;
        err_count = 0;
        n_tests = 0;
        cycles = 0;
        repeat (6) @(posedge MCLK);
        RST_B <= 1'b1;
        t_reset();
        t_config();
        t_lookup();
        t_carry();
        t_clock();
        t_enable();
        t_setreset();
        summarize();
    end
endmodule : tb
